// [rtl/cram_pkg.sv]
// package: ram types, register map and reset values
package cram_pkg;
	// ********************************************************
	// default geometry
	// ********************************************************
	localparam int DEPTH_DEF = 256;
	localparam int WIDTH_DEF = 16;
	localparam int RATIO_DEF = 1;
	localparam int NXRD_DEF  = 2;

	// ********************************************************
	// register map
	// ********************************************************
	localparam int          APB_AW       = 12;
	localparam logic [11:0] CTRL_OFF     = 12'h000;
	localparam logic [11:0] STAT_OFF     = 12'h004;
	localparam int          CTRL_CFG_LSB = 0;
	localparam int          CTRL_CFG_W   = 7;
	localparam int          STAT_LSB     = 0;
	localparam int          STAT_W       = 2;
	localparam logic [6:0]  CTRL_RST     = 7'h10;
	localparam logic [1:0]  STAT_RST     = 2'h0;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		RDW_READ_FIRST,
		RDW_WRITE_FIRST,
		RDW_NO_CHANGE
	} cram_rdw_t;

	// bit 0 upward: rdw_a[1:0], rdw_b[3:2], blk 4, oreg_a 5, oreg_b 6
	typedef struct packed {
		logic      oreg_b;
		logic      oreg_a;
		logic      blk;
		cram_rdw_t rdw_b;
		cram_rdw_t rdw_a;
	} cram_cfg_t;

	typedef struct packed {
		logic rw_hit;
		logic ww_hit;
	} cram_evt_t;
endpackage : cram_pkg

// [rtl/cram_rd_port.sv]
// module: read data path of one ram port
`timescale 1ns/1ns
module cram_rd_port
	import cram_pkg::*;
#(
	parameter int           W       = WIDTH_DEF,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_b_i,
	// port controls
	input  wire logic      en_i,
	input  wire logic      we_i,
	input  wire logic      orst_i,
	input  wire logic      blk_i,
	input  wire logic      oreg_i,
	input  wire cram_rdw_t rdw_i,
	// array word before the edge, and word being written
	input  wire logic [W-1:0] old_i,
	input  wire logic [W-1:0] new_i,
	// read data
	output logic [W-1:0]      rdata_o
);
	logic [W-1:0] q1_q;
	logic [W-1:0] q2_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q1_q <= '0;
		end else if (en_i) begin // [R13]
			if (orst_i) begin
				q1_q <= RST_VAL; // [R14] [R19]
			end else begin
				case (rdw_i)
				RDW_WRITE_FIRST: q1_q <= we_i ? new_i : old_i; // [R05]
				RDW_NO_CHANGE: begin
					if (!we_i) begin
						q1_q <= old_i; // [R06]
					end
				end
				default: q1_q <= old_i; // [R04]
				endcase
			end
		end
	end

	// extra stage also takes the reset so the visible output resets
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q2_q <= '0;
		end else if (en_i) begin
			q2_q <= orst_i ? RST_VAL : q1_q; // [R15] [R19]
		end
	end

	// distributed style bypasses every register
	assign rdata_o = !blk_i ? old_i : (oreg_i ? q2_q : q1_q); // [R02] [R03]
endmodule : cram_rd_port

// [rtl/cram_apb_regs.sv]
// module: apb slave holding ram configuration and hit status
`timescale 1ns/1ns
module cram_apb_regs
	import cram_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// apb
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [APB_AW-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// block side
	input  wire cram_evt_t         evt_i,
	output cram_cfg_t              cfg_o
);
	logic            hit_ctrl;
	logic            hit_stat;
	logic            wr_acc;
	logic [STAT_W-1:0] clr;
	logic [STAT_W-1:0] sts_q;
	logic [31:0]     prdata_q;

	assign hit_ctrl = (paddr_i == CTRL_OFF);
	assign hit_stat = (paddr_i == STAT_OFF);
	assign wr_acc   = psel_i && penable_i && pwrite_i;
	assign clr      = (wr_acc && hit_stat) ?
		pwdata_i[STAT_LSB +: STAT_W] : '0;
	// zero wait states: every access completes in its first access cycle
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !hit_ctrl && !hit_stat;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_o <= cram_cfg_t'(CTRL_RST);
		end else if (wr_acc && hit_ctrl) begin
			cfg_o <= cram_cfg_t'(pwdata_i[CTRL_CFG_LSB +: CTRL_CFG_W]);
		end
	end

	// write one to clear; a hit in the same cycle stays set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sts_q <= STAT_RST;
		end else begin
			sts_q <= (sts_q & ~clr) | evt_i;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_q <= '0;
		end else if (psel_i && !penable_i) begin
			if (hit_ctrl) begin
				prdata_q <= {25'h0000000, cfg_o};
			end else if (hit_stat) begin
				prdata_q <= {30'h00000000, sts_q};
			end else begin
				prdata_q <= '0;
			end
		end
	end
	assign prdata_o = prdata_q;
endmodule : cram_apb_regs

// [rtl/cram_top.sv]
// module: configurable dual-write ram with extra read ports
//
// Function
// R01 - array changes only on a clock edge of a writing port
// R02 - distributed style: read data follows address combinationally
// R03 - block style: read data registered on the port clock edge
// R04 - read-first: writing edge outputs the word held before
// R05 - write-first: writing edge outputs the newly written word
// R06 - no-change: output holds on write cycles, updates otherwise
// R07 - each port picks its own read-during-write mode
// R08 - writes always complete; other port reads old word
// R09 - single, simple dual and true dual port; port widths may differ
// R10 - at most two write ports
// R11 - one writer may be joined by several read-only ports
// R12 - each port has own clock, enable, write enable, output reset; here both ports share clk_i
// R13 - block style: ram enable gates all port activity
// R14 - block style: output register reset on the port clock
// R15 - block style: optional extra output stage adds one cycle
// R16 - any depth and width; no parity logic
// R17 - user drives write enable with valid address and data
// R18 - addresses are unsigned, every value a distinct word
// R19 - output reset on an enabled edge loads a fixed constant
`timescale 1ns/1ns
module cram_top
	import cram_pkg::*;
#(
	parameter int              DEPTH     = DEPTH_DEF,
	parameter int              DW        = WIDTH_DEF,
	parameter int              RATIO     = RATIO_DEF,
	parameter int              N_XRD     = NXRD_DEF,
	parameter logic [DW-1:0]   RST_VAL_A = '0,
	parameter logic [DW*RATIO-1:0] RST_VAL_B = '0
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// apb
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [APB_AW-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// port a
	input  wire logic              en_a_i,
	input  wire logic              we_a_i,
	input  wire logic              orst_a_i,
	input  wire logic [$clog2(DEPTH)-1:0] addr_a_i,
	input  wire logic [DW-1:0]     write_word_in_a_i,
	output logic [DW-1:0]          rdata_a_o,
	// port b, RATIO words wide
	input  wire logic              en_b_i,
	input  wire logic              we_b_i,
	input  wire logic              orst_b_i,
	input  wire logic [$clog2(DEPTH)-$clog2(RATIO)-1:0] addr_b_i,
	input  wire logic [DW*RATIO-1:0] write_word_in_b_i,
	output logic [DW*RATIO-1:0]    rdata_b_o,
	// read-only ports
	input  wire logic [N_XRD-1:0][$clog2(DEPTH)-1:0] xaddr_i,
	output logic [N_XRD-1:0][DW-1:0] xdata_o
);
	localparam int AW  = $clog2(DEPTH);
	localparam int RB  = $clog2(RATIO);
	localparam int BAW = AW - RB;
	localparam int BDW = DW * RATIO;

	// ********************************************************
	// storage and write ports
	// ********************************************************
	logic [DW-1:0]  mem [DEPTH];
	logic [AW-1:0]  b_idx [RATIO];
	logic [DW-1:0]  old_a;
	logic [BDW-1:0] old_b;
	logic           wr_a;
	logic           wr_b;
	logic           same_grp;
	cram_cfg_t      cfg;
	cram_evt_t      evt;

	assign wr_a = en_a_i && we_a_i; // [R17]
	assign wr_b = en_b_i && we_b_i; // [R17]

	// port b word k lives at a-address addr_b*RATIO+k
	for (genvar k = 0; k < RATIO; k++) begin : g_lane
		assign b_idx[k] = AW'(int'(addr_b_i) * RATIO + k); // [R18] [R09]
		assign old_b[k*DW +: DW] = mem[b_idx[k]];
	end

	assign old_a = mem[addr_a_i]; // [R18]

	// no reset on the array: contents are undefined until written.
	// with both ports on one address, port b's data is kept.
	always_ff @(posedge clk_i) begin
		if (wr_a) begin
			mem[addr_a_i] <= write_word_in_a_i; // [R01] [R16] [R10]
		end
		if (wr_b) begin
			for (int k = 0; k < RATIO; k++) begin
				mem[b_idx[k]] <= write_word_in_b_i[k*DW +: DW]; // [R01]
			end
		end
	end

	// ********************************************************
	// per-port read paths
	// ********************************************************
	// both ports share clk_i; enables, writes and resets stay apart
	cram_rd_port #(
		.W       (DW),
		.RST_VAL (RST_VAL_A)
	) u_rd_a (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (en_a_i), // [R12]
		.we_i    (we_a_i),
		.orst_i  (orst_a_i),
		.blk_i   (cfg.blk),
		.oreg_i  (cfg.oreg_a),
		.rdw_i   (cfg.rdw_a), // [R07]
		.old_i   (old_a),
		.new_i   (write_word_in_a_i),
		.rdata_o (rdata_a_o)
	);

	cram_rd_port #(
		.W       (BDW),
		.RST_VAL (RST_VAL_B)
	) u_rd_b (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (en_b_i), // [R12]
		.we_i    (we_b_i),
		.orst_i  (orst_b_i),
		.blk_i   (cfg.blk),
		.oreg_i  (cfg.oreg_b),
		.rdw_i   (cfg.rdw_b), // [R07]
		.old_i   (old_b),
		.new_i   (write_word_in_b_i),
		.rdata_o (rdata_b_o)
	);

	// ********************************************************
	// read-only ports
	// ********************************************************
	// meant for addresses other than the one being written
	for (genvar j = 0; j < N_XRD; j++) begin : g_xrd
		logic [DW-1:0] xq_q;
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				xq_q <= '0;
			end else begin
				xq_q <= mem[xaddr_i[j]]; // [R11]
			end
		end
		assign xdata_o[j] = cfg.blk ? xq_q : mem[xaddr_i[j]]; // [R11]
	end

	// ********************************************************
	// register slave and address hits
	// ********************************************************
	assign same_grp = (BAW'(addr_a_i >> RB) == addr_b_i);
	// one driver for the whole struct; rw_hit flags a cross-port
	// read of a written word, which returns the old word
	assign evt = '{
		rw_hit: same_grp && ((wr_a && en_b_i && !we_b_i) ||
			(wr_b && en_a_i && !we_a_i)), // [R08]
		ww_hit: wr_a && wr_b && same_grp
	};

	cram_apb_regs u_regs (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o),
		.evt_i     (evt),
		.cfg_o     (cfg)
	);

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic blk_nr_a;
	logic blk_nr_b;
	assign blk_nr_a = cfg.blk && !cfg.oreg_a;
	assign blk_nr_b = cfg.blk && !cfg.oreg_b;

	a_write_stores: assert property ( // [R01]
		wr_a && !(wr_b && same_grp)
		|=> mem[$past(addr_a_i)] == $past(write_word_in_a_i)
	) else $error("port a write not stored");

	a_idle_keeps: assert property ( // [R01]
		!wr_a && !wr_b |=> mem[$past(addr_a_i)] === $past(old_a)
	) else $error("array changed without a write");

	a_dist_follows: assert property ( // [R02]
		!cfg.blk |-> rdata_a_o === mem[addr_a_i] &&
			xdata_o[0] === mem[xaddr_i[0]]
	) else $error("distributed read not combinational");

	a_rf_old_word: assert property ( // [R04]
		(blk_nr_a && en_a_i && we_a_i && !orst_a_i &&
			cfg.rdw_a == RDW_READ_FIRST) ##1 $stable(cfg)
		|-> rdata_a_o === $past(old_a)
	) else $error("read-first did not show old word");

	a_wf_new_word: assert property ( // [R05] [R07]
		(blk_nr_b && wr_b && !orst_b_i &&
			cfg.rdw_b == RDW_WRITE_FIRST) ##1 $stable(cfg)
		|-> rdata_b_o == $past(write_word_in_b_i)
	) else $error("write-first did not show new word");

	a_nc_holds: assert property ( // [R06]
		(blk_nr_a && wr_a && !orst_a_i &&
			cfg.rdw_a == RDW_NO_CHANGE) ##1 $stable(cfg)
		|-> $stable(rdata_a_o)
	) else $error("no-change output moved on write");

	a_cross_old: assert property ( // [R08]
		(blk_nr_b && wr_a && !wr_b && en_b_i && !orst_b_i &&
			same_grp) ##1 $stable(cfg)
		|-> rdata_b_o === $past(old_b)
	) else $error("cross-port read did not return old word");

	a_en_gates: assert property ( // [R13]
		(cfg.blk && !en_a_i) ##1 $stable(cfg)
		|-> $stable(rdata_a_o)
	) else $error("disabled port output changed");

	a_out_reset: assert property ( // [R14] [R19]
		(blk_nr_b && en_b_i && orst_b_i) ##1 $stable(cfg)
		|-> rdata_b_o == RST_VAL_B
	) else $error("output reset value not loaded");

	a_oreg_lat: assert property ( // [R15]
		(cfg.blk && cfg.oreg_a && en_a_i && !we_a_i && !orst_a_i)
		##1 (en_a_i && !orst_a_i && $stable(cfg))
		##1 $stable(cfg)
		|-> rdata_a_o === $past(old_a, 2)
	) else $error("output stage latency wrong");

	a_xrd_reg: assert property ( // [R11]
		(cfg.blk && rst_b_i) ##1 $stable(cfg.blk)
		|-> xdata_o[0] === $past(mem[xaddr_i[0]])
	) else $error("read-only port data wrong");

	// never-written words read as unknown, hence the case equality
	a_b_stores: assert property ( // [R01] [R09]
		wr_b |=> mem[$past(b_idx[0])] ===
			$past(write_word_in_b_i[DW-1:0])
	) else $error("port b write not stored");

	a_idle_keeps_b: assert property ( // [R01]
		!wr_a && !wr_b
		|=> mem[$past(b_idx[0])] === $past(old_b[DW-1:0])
	) else $error("port b word changed without a write");

	a_rf_old_b: assert property ( // [R04] [R07]
		(blk_nr_b && en_b_i && we_b_i && !orst_b_i &&
			cfg.rdw_b == RDW_READ_FIRST) ##1 $stable(cfg)
		|-> rdata_b_o === $past(old_b)
	) else $error("read-first port b did not show old word");

	a_wf_new_a: assert property ( // [R05]
		(blk_nr_a && wr_a && !orst_a_i &&
			cfg.rdw_a == RDW_WRITE_FIRST) ##1 $stable(cfg)
		|-> rdata_a_o == $past(write_word_in_a_i)
	) else $error("write-first port a did not show new word");

	a_nc_holds_b: assert property ( // [R06]
		(blk_nr_b && wr_b && !orst_b_i &&
			cfg.rdw_b == RDW_NO_CHANGE) ##1 $stable(cfg)
		|-> $stable(rdata_b_o)
	) else $error("no-change port b output moved on write");

	a_nc_read: assert property ( // [R06]
		(blk_nr_a && en_a_i && !we_a_i && !orst_a_i &&
			cfg.rdw_a == RDW_NO_CHANGE) ##1 $stable(cfg)
		|-> rdata_a_o === $past(old_a)
	) else $error("no-change port a did not update on read");

	a_out_reset_a: assert property ( // [R14] [R19]
		(cfg.blk && en_a_i && orst_a_i) ##1 $stable(cfg)
		|-> rdata_a_o == RST_VAL_A
	) else $error("port a output reset value not loaded");

	a_en_gates_b: assert property ( // [R12] [R13]
		(cfg.blk && !en_b_i) ##1 $stable(cfg)
		|-> $stable(rdata_b_o)
	) else $error("disabled port b output changed");

	a_cross_old_a: assert property ( // [R08]
		(blk_nr_a && wr_b && !wr_a && en_a_i && !orst_a_i &&
			same_grp) ##1 $stable(cfg)
		|-> rdata_a_o === $past(old_a)
	) else $error("cross-port read on a did not return old word");

	a_code3_rf: assert property ( // [R04]
		(blk_nr_a && wr_a && !orst_a_i && cfg.rdw_a == 2'h3)
		##1 $stable(cfg)
		|-> rdata_a_o === $past(old_a)
	) else $error("mode code 3 did not act as read-first");

	a_cfg_write: assert property ( // [R07]
		psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFF
		|=> cfg == $past(pwdata_i[CTRL_CFG_LSB +: CTRL_CFG_W])
	) else $error("configuration write did not land");

	a_xrd_dist: assert property ( // [R02] [R11]
		!cfg.blk |-> xdata_o[N_XRD-1] === mem[xaddr_i[N_XRD-1]]
	) else $error("read-only port not combinational");

	a_dist_b: assert property ( // [R02]
		!cfg.blk |-> rdata_b_o === old_b
	) else $error("distributed read on b not combinational");

	a_xrd_reg_hi: assert property ( // [R11] [R03]
		(cfg.blk && rst_b_i) ##1 $stable(cfg.blk)
		|-> xdata_o[N_XRD-1] === $past(mem[xaddr_i[N_XRD-1]])
	) else $error("last read-only port data wrong");

	// ********************************************************
	// scenarios covered
	// ********************************************************
	c_wf_write: cover property (
		cfg.blk && wr_a && cfg.rdw_a == RDW_WRITE_FIRST);
	c_nc_write: cover property (
		cfg.blk && wr_a && cfg.rdw_a == RDW_NO_CHANGE ##1 wr_a);
	c_cross_hit: cover property (evt.rw_hit && cfg.blk);
	c_dual_write: cover property (evt.ww_hit);
	c_oreg_reset: cover property (
		cfg.blk && cfg.oreg_a && en_a_i && orst_a_i);
endmodule : cram_top

// [test/cram_user.sv]
// partner model: user logic driving one ram port
`timescale 1ns/1ns
module cram_user #(
	parameter int AW = 8,
	parameter int W  = 16
) (
	// clock
	input  wire logic     clk_i,
	// port drive
	output logic          en_o,
	output logic          we_o,
	output logic          orst_o,
	output logic [AW-1:0] addr_o,
	output logic [W-1:0]  wdata_o
);
	logic [AW+W+2:0] q[$];
	logic [AW+W+2:0] op;

	initial begin
		{en_o, we_o, orst_o, addr_o, wdata_o} = '0;
	end
	// one queued op per edge; idle keeps the address, spoils the data
	always @(posedge clk_i) begin
		if (q.size() > 0)
			op = q.pop_front();
		else
			op = {3'b000, addr_o, wdata_o};
		{en_o, we_o, orst_o, addr_o} <= op[AW+W+2:W];
		wdata_o <= op[AW+W+1] ? op[W-1:0] : ~wdata_o;
	end
	task automatic push(input logic e, w, r, input logic [AW-1:0] a,
		input logic [W-1:0] d);
		q.push_back({e, w, r, a, d});
	endtask : push
endmodule : cram_user

// [test/tb_cram_top.sv]
// testbench: self-checking run of the configurable ram
`timescale 1ns/1ns
module tb_cram_top;
	import cram_pkg::*;
	// ********
	// signals
	// ********
	logic                   clk_i;
	logic                   rst_b_i;
	logic                   psel_i;
	logic                   penable_i;
	logic                   pwrite_i;
	logic [APB_AW-1:0]      paddr_i;
	logic [31:0]            pwdata_i;
	logic [31:0]            prdata_o;
	logic                   pready_o;
	logic                   pslverr_o;
	logic                   en_a, we_a, orst_a, en_b, we_b, orst_b;
	logic [7:0]             addr_a, addr_b;
	logic [15:0]            wd_a, wd_b, rd_a, rd_b;
	logic [1:0][7:0]        xaddr_i;
	logic [1:0][15:0]       xdata_o;
	logic [31:0]            rd;
	logic                   er;
	int                     n_errors;
	int                     cmp_count;

	cram_top #(.RST_VAL_A(16'h00c3), .RST_VAL_B(16'h003c)) i_cram_top (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .en_a_i(en_a), .we_a_i(we_a),
		.orst_a_i(orst_a), .addr_a_i(addr_a), .write_word_in_a_i(wd_a),
		.rdata_a_o(rd_a), .en_b_i(en_b), .we_b_i(we_b), .orst_b_i(orst_b),
		.addr_b_i(addr_b), .write_word_in_b_i(wd_b), .rdata_b_o(rd_b),
		.xaddr_i(xaddr_i), .xdata_o(xdata_o));
	cram_user i_cram_user_a (.clk_i(clk_i), .en_o(en_a), .we_o(we_a),
		.orst_o(orst_a), .addr_o(addr_a), .wdata_o(wd_a));
	cram_user i_cram_user_b (.clk_i(clk_i), .en_o(en_b), .we_o(we_b),
		.orst_o(orst_b), .addr_o(addr_b), .wdata_o(wd_b));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ********
	// helpers
	// ********
	task automatic pa(input logic e, w, r, input logic [7:0] a,
		input logic [15:0] d);
		i_cram_user_a.push(e, w, r, a, d);
	endtask : pa
	task automatic pb(input logic e, w, r, input logic [7:0] a,
		input logic [15:0] d);
		i_cram_user_b.push(e, w, r, a, d);
	endtask : pb
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic chk_word(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk_word
	// slave answers with zero waits, but the wait stays open-ended
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		#1;
	endtask : apb
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp,
		input logic e);
		apb(1'b0, a, 32'h0);
		cmp_count++;
		if (rd !== exp || er !== e) begin
			n_errors++;
			$display("wrong value at %0t: reg %h got %h", $time, a, rd);
		end
	endtask : reg_rd
	function automatic logic [15:0] exp_rdw(input cram_rdw_t m,
		input logic [15:0] o, n, p);
		case (m)
			RDW_WRITE_FIRST: return n;
			RDW_NO_CHANGE:   return p;
			default:         return o;
		endcase
	endfunction : exp_rdw
	// ********
	// scenarios
	// ********
	task automatic t_regs;
		reg_rd(CTRL_OFF, {25'h0, CTRL_RST}, 1'b0);
		reg_rd(STAT_OFF, 32'h0, 1'b0);
		apb(1'b1, 12'h008, 32'hffffffff);
		reg_rd(12'h008, 32'h0, 1'b1);
		apb(1'b1, CTRL_OFF, 32'hffffffff);
		reg_rd(CTRL_OFF, 32'h7f, 1'b0);
		$display("regs done");
	endtask : t_regs
	task automatic t_rdw(input int m);
		cram_rdw_t ma, mb;
		logic [15:0] oa, ob, na, nb;
		ma = cram_rdw_t'(m);
		mb = cram_rdw_t'((m + 1) % 4);
		oa = {8'h11, 8'(m)};
		ob = {8'h22, 8'(m)};
		na = {8'h33, 8'(m)};
		nb = {8'h44, 8'(m)};
		apb(1'b1, CTRL_OFF, {25'h0, 3'b001, 2'(mb), 2'(ma)});
		pa(1, 1, 0, 8'd10, oa);
		pb(1, 1, 0, 8'd20, ob);
		pa(1, 0, 0, 8'd20, 16'h0);
		pb(1, 0, 0, 8'd10, 16'h0);
		tick(3);
		chk_word(rd_a, ob);
		chk_word(rd_b, oa);
		pa(1, 1, 0, 8'd10, na);
		pb(1, 1, 0, 8'd20, nb);
		pa(1, 0, 0, 8'd20, 16'h0);
		pb(1, 1, 0, 8'd20, ~nb);
		tick(2);
		chk_word(rd_a, exp_rdw(ma, oa, na, ob));
		chk_word(rd_b, exp_rdw(mb, ob, nb, oa));
		tick(1);
		chk_word(rd_a, nb);
		$display("mode %0d done", m);
	endtask : t_rdw
	task automatic t_hit;
		apb(1'b1, STAT_OFF, 32'h3);
		reg_rd(STAT_OFF, 32'h0, 1'b0);
		pa(1, 1, 0, 8'd40, 16'haaaa);
		pb(1, 1, 0, 8'd40, 16'h5555);
		pa(1, 0, 0, 8'd40, 16'h0);
		tick(3);
		chk_word(rd_a, 16'h5555);
		reg_rd(STAT_OFF, 32'h1, 1'b0);
		$display("hit done");
	endtask : t_hit
	task automatic t_ctl;
		apb(1'b1, CTRL_OFF, 32'h10);
		pa(1, 1, 0, 8'd30, 16'h5a5a);
		pa(1, 0, 0, 8'd30, 16'h0);
		pa(0, 1, 0, 8'd30, 16'hffff);
		pa(0, 0, 1, 8'd31, 16'h0);
		tick(5);
		chk_word(rd_a, 16'h5a5a);
		pa(1, 0, 0, 8'd30, 16'h0);
		pb(1, 0, 1, 8'd30, 16'h0);
		tick(2);
		chk_word(rd_a, 16'h5a5a);
		chk_word(rd_b, 16'h003c);
		apb(1'b1, CTRL_OFF, 32'h30);
		pa(1, 0, 1, 8'd30, 16'h0);
		pa(1, 0, 0, 8'd30, 16'h0);
		pa(1, 0, 0, 8'd30, 16'h0);
		tick(2);
		chk_word(rd_a, 16'h00c3);
		tick(1);
		chk_word(rd_a, 16'h00c3);
		tick(1);
		chk_word(rd_a, 16'h5a5a);
		$display("ctl done");
	endtask : t_ctl
	task automatic t_dist;
		apb(1'b1, CTRL_OFF, 32'h0);
		pa(1, 1, 0, 8'hff, 16'h1234);
		pa(1, 1, 0, 8'hff, 16'hbeef);
		tick(2);
		chk_word(rd_a, 16'h1234);
		@(posedge clk_i);
		xaddr_i <= {8'd10, 8'd20};
		#1;
		chk_word(rd_a, 16'hbeef);
		chk_word(xdata_o[1], 16'h3303);
		chk_word(xdata_o[0], 16'hbbfc);
		$display("dist done");
	endtask : t_dist
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// ********
	// main
	// ********
	initial begin
		{psel_i, penable_i, pwrite_i, rst_b_i} = '0;
		paddr_i = '0;
		pwdata_i = '0;
		xaddr_i = '0;
		n_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		for (int m = 0; m < 4; m++)
			t_rdw(m);
		t_hit();
		t_ctl();
		t_dist();
		tally_and_finish();
	end
	// whole run is about a hundred cycles
	initial begin
		#20000;
		n_errors++;
		tally_and_finish();
	end
endmodule : tb_cram_top
